// >>> verilog/attribution_pkg.sv
// How it works
// - Report secure, entry-callable or non-secure, plus region.
// - Flag an address range exempt from checking.
// - 512MB blocks aliased into two 256MB halves.
// - Secure attribution comes from address bit 28.
// - Entry-callable indication mirrors the secure indication.
// - Region from bits 31:28; region valid always high.
// - Every distinct region gets a unique number.
// - Exempt output high inside debug table ranges.
// - Regions never overlap one another.
// - Keep the mapping simple with limited configurability.
// - Either half may be secure; lower by default.
// - Shared-system mode follows the system-wide arrangement.
package attribution_pkg;

  // Address and data widths of the attribution port and the register bus.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int BUS_ADDR_W = 5;
  localparam int BE_W = 4;

  // Address fields that build the map.
  localparam int SECURE_BIT = 28;
  localparam int REGION_HI = 31;
  localparam int REGION_LO = 28;
  localparam int REGION_W = 4;

  // Register byte offsets on the bus.
  localparam logic [BUS_ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [BUS_ADDR_W-1:0] OFS_EXEMPT_BASE = 5'h04;
  localparam logic [BUS_ADDR_W-1:0] OFS_EXEMPT_LIMIT = 5'h08;
  localparam logic [BUS_ADDR_W-1:0] OFS_PROBE_ADDR = 5'h0C;
  localparam logic [BUS_ADDR_W-1:0] OFS_PROBE_RESULT = 5'h10;
  localparam logic [BUS_ADDR_W-1:0] OFS_LIVE_STATUS = 5'h14;

  // Control register fields.
  localparam int CTRL_LOWER_SECURE = 0;
  localparam int CTRL_EXEMPT_EN = 1;
  localparam int CTRL_SYS_MAP = 2;
  localparam int CTRL_LOCK = 3;
  localparam int CTRL_W = 4;

  // Result fields shared by the probe and live status registers.
  localparam int RES_SECURE = 0;
  localparam int RES_ENTRY = 1;
  localparam int RES_VALID = 2;
  localparam int RES_EXEMPT = 3;
  localparam int RES_REGION_LO = 8;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;
  localparam logic [ADDR_W-1:0] EXEMPT_BASE_RESET = 32'hF0000000;
  localparam logic [ADDR_W-1:0] EXEMPT_LIMIT_RESET = 32'hF0000FFF;
  localparam logic [ADDR_W-1:0] PROBE_ADDR_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // Bus answer sequencing.
  typedef enum logic {BUS_IDLE, BUS_DONE} bus_e;

endpackage

// >>> verilog/attribution_if.sv
`timescale 1ns/100ps
// Carries one address query, its map settings and its attribution.
interface attribution_if;
  import attribution_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic lower_secure;
  logic exempt_en;
  logic sys_map;
  logic sys_secure;
  logic sys_entry;
  logic [ADDR_W-1:0] exempt_base;
  logic [ADDR_W-1:0] exempt_limit;
  logic secure;
  logic entry_callable;
  logic [REGION_W-1:0] region;
  logic region_valid;
  logic exempt;

  modport unit (
    input addr, lower_secure, exempt_en, sys_map, sys_secure, sys_entry,
    input exempt_base, exempt_limit,
    output secure, entry_callable, region, region_valid, exempt
  );
  modport user (
    output addr, lower_secure, exempt_en, sys_map, sys_secure, sys_entry,
    output exempt_base, exempt_limit,
    input secure, entry_callable, region, region_valid, exempt
  );
endinterface

// >>> verilog/attribution_decode.sv
`timescale 1ns/100ps
// Stateless address decode; a plain gate path for timing-critical use.
module attribution_decode
  import attribution_pkg::*;
(
  attribution_if.unit port
);

  logic half_secure;

  // The secure half is chosen by bit 28 and the polarity setting.
  assign half_secure = port.addr[SECURE_BIT] ^ port.lower_secure;

  // Shared-system mode hands attribution to the system-wide map.
  assign port.secure = port.sys_map ? port.sys_secure
                                    : half_secure;
  assign port.entry_callable = port.sys_map ? port.sys_entry
                                            : half_secure;

  // Each 256MB half gets its own number, so none repeat or overlap.
  assign port.region = port.addr[REGION_HI:REGION_LO];
  assign port.region_valid = 1'b1;

  // Debug table window bypasses attribution checks.
  assign port.exempt = port.exempt_en
                       && (port.addr >= port.exempt_base)
                       && (port.addr <= port.exempt_limit);

endmodule

// >>> verilog/attribution_map.sv
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
// Fixed attribution map with a small register set for settings and probing.
// The attribution path is kept combinational so the core sees its answer
// in the same cycle as the address; only the bus side is registered.
module attribution_map
  import attribution_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic SYS_SECURE_I,
  input wire logic SYS_ENTRY_CALLABLE_I,
  output logic SECURE_O,
  output logic ENTRY_CALLABLE_O,
  output logic [REGION_W-1:0] REGION_O,
  output logic REGION_VALID_O,
  output logic EXEMPT_O,
  input wire logic [BUS_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA_I,
  input wire logic [BE_W-1:0] AVS_BYTEENABLE_I,
  output logic [DATA_W-1:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O
);

  // Settings held by software.
  logic [CTRL_W-1:0] ctrl;
  logic [ADDR_W-1:0] exempt_base;
  logic [ADDR_W-1:0] exempt_limit;
  logic [ADDR_W-1:0] probe_addr;

  // Registered views of the two decoders.
  logic [DATA_W-1:0] probe_result;
  logic [DATA_W-1:0] live_status;

  // Bus sequencing state.
  bus_e bus_state;
  logic [DATA_W-1:0] read_word;
  logic write_take;
  logic locked;
  logic cfg_write_ok;

  // One decoder serves the core, the other answers software probes.
  attribution_if live_if ();
  attribution_if probe_if ();

  // Merges the enabled byte lanes of a write into an old word.
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [BE_W-1:0] lanes
  );
    logic [DATA_W-1:0] result;
    result = old_word;
    for (int i = 0; i < BE_W; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // Packs one decoder's answer into the shared result layout.
  function automatic logic [DATA_W-1:0] pack_result(
    input logic secure,
    input logic entry_callable,
    input logic region_valid,
    input logic exempt,
    input logic [REGION_W-1:0] region
  );
    logic [DATA_W-1:0] result;
    result = WORD_ZERO;
    result[RES_SECURE] = secure;
    result[RES_ENTRY] = entry_callable;
    result[RES_VALID] = region_valid;
    result[RES_EXEMPT] = exempt;
    result[RES_REGION_LO +: REGION_W] = region;
    return result;
  endfunction

  // Settings feed both decoders identically, so probes match the core.
  assign live_if.addr = ADDR_I;
  assign live_if.lower_secure = ctrl[CTRL_LOWER_SECURE];
  assign live_if.exempt_en = ctrl[CTRL_EXEMPT_EN];
  assign live_if.sys_map = ctrl[CTRL_SYS_MAP];
  assign live_if.sys_secure = SYS_SECURE_I;
  assign live_if.sys_entry = SYS_ENTRY_CALLABLE_I;
  assign live_if.exempt_base = exempt_base;
  assign live_if.exempt_limit = exempt_limit;

  assign probe_if.addr = probe_addr;
  assign probe_if.lower_secure = ctrl[CTRL_LOWER_SECURE];
  assign probe_if.exempt_en = ctrl[CTRL_EXEMPT_EN];
  assign probe_if.sys_map = ctrl[CTRL_SYS_MAP];
  assign probe_if.sys_secure = SYS_SECURE_I;
  assign probe_if.sys_entry = SYS_ENTRY_CALLABLE_I;
  assign probe_if.exempt_base = exempt_base;
  assign probe_if.exempt_limit = exempt_limit;

  attribution_decode live_decode (
    .port (live_if.unit)
  );

  attribution_decode probe_decode (
    .port (probe_if.unit)
  );

  // The core's answer stays a gate path: a flop here would cost a cycle.
  assign SECURE_O = live_if.secure;
  assign ENTRY_CALLABLE_O = live_if.entry_callable;
  assign REGION_O = live_if.region;
  assign REGION_VALID_O = live_if.region_valid;
  assign EXEMPT_O = live_if.exempt;

  // A write is applied only at the edge where waitrequest is seen low.
  assign write_take = (bus_state == BUS_DONE) && AVS_WRITE_I;

  // Once locked, the map cannot be reshaped until reset.
  assign locked = ctrl[CTRL_LOCK];
  assign cfg_write_ok = write_take && !locked;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    read_word = WORD_ZERO;
    unique case (AVS_ADDRESS_I)
      OFS_CTRL: begin
        read_word[CTRL_W-1:0] = ctrl;
      end
      OFS_EXEMPT_BASE: begin
        read_word = exempt_base;
      end
      OFS_EXEMPT_LIMIT: begin
        read_word = exempt_limit;
      end
      OFS_PROBE_ADDR: begin
        read_word = probe_addr;
      end
      OFS_PROBE_RESULT: begin
        read_word = probe_result;
      end
      OFS_LIVE_STATUS: begin
        read_word = live_status;
      end
      default: begin
        read_word = WORD_ZERO;
      end
    endcase
  end

  // Bus answer: one waitrequest-low cycle per request, then idle again.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_state <= BUS_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      unique case (bus_state)
        BUS_IDLE: begin
          if (AVS_READ_I || AVS_WRITE_I) begin
            bus_state <= BUS_DONE;
            AVS_WAITREQUEST_O <= 1'b0;
          end
        end
        BUS_DONE: begin
          bus_state <= BUS_IDLE;
          AVS_WAITREQUEST_O <= 1'b1;
        end
      endcase
    end
  end

  // Read data are loaded together with the waitrequest drop.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      AVS_READDATA_O <= WORD_ZERO;
    end else if (bus_state == BUS_IDLE && AVS_READ_I) begin
      AVS_READDATA_O <= read_word;
    end
  end

  // Control register; software can only set the lock bit, and only reset clears it.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RESET;
    end else if (cfg_write_ok && AVS_ADDRESS_I == OFS_CTRL
                 && AVS_BYTEENABLE_I[0]) begin
      ctrl <= AVS_WRITEDATA_I[CTRL_W-1:0];
    end
  end

  // Lower bound of the exempt window, inclusive.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      exempt_base <= EXEMPT_BASE_RESET;
    end else if (cfg_write_ok && AVS_ADDRESS_I == OFS_EXEMPT_BASE) begin
      exempt_base <= merge_bytes(exempt_base, AVS_WRITEDATA_I,
                                 AVS_BYTEENABLE_I);
    end
  end

  // Upper bound of the exempt window, inclusive.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      exempt_limit <= EXEMPT_LIMIT_RESET;
    end else if (cfg_write_ok && AVS_ADDRESS_I == OFS_EXEMPT_LIMIT) begin
      exempt_limit <= merge_bytes(exempt_limit, AVS_WRITEDATA_I,
                                  AVS_BYTEENABLE_I);
    end
  end

  // Probe address stays writable after lock; it changes no mapping.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      probe_addr <= PROBE_ADDR_RESET;
    end else if (write_take && AVS_ADDRESS_I == OFS_PROBE_ADDR) begin
      probe_addr <= merge_bytes(probe_addr, AVS_WRITEDATA_I,
                                AVS_BYTEENABLE_I);
    end
  end

  // Probe answer, refreshed every cycle from the second decoder.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      probe_result <= WORD_ZERO;
    end else begin
      probe_result <= pack_result(probe_if.secure, probe_if.entry_callable,
                                  probe_if.region_valid, probe_if.exempt,
                                  probe_if.region);
    end
  end

  // Snapshot of the core's current answer, one cycle behind it.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      live_status <= WORD_ZERO;
    end else begin
      live_status <= pack_result(live_if.secure, live_if.entry_callable,
                                 live_if.region_valid, live_if.exempt,
                                 live_if.region);
    end
  end

endmodule

// >>> verif/core_model.sv
`timescale 1ns/100ps
// Stands in for the core: issues addresses, judges entries, packs queries.
module core_model
  import attribution_pkg::*;
(
  input wire logic [ADDR_W-1:0] target_i,
  input wire logic gateway_i,
  input wire logic secure_i,
  input wire logic entry_i,
  input wire logic [REGION_W-1:0] region_i,
  input wire logic valid_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic fault_o,
  output logic [7:0] query_o
);
  // The address goes out in the cycle it is asked for.
  assign addr_o = target_i;
  // A gateway entry outside entry-callable space faults.
  assign fault_o = gateway_i && !entry_i;
  // A secure query returns region, valid flag and attributes.
  assign query_o = {region_i, valid_i, 1'b0, entry_i, secure_i};
endmodule

// >>> verif/attribution_map_asserts.sv
`timescale 1ns/100ps
// Watches the attribution answers and the bus answer timing.
module attribution_map_asserts
  import attribution_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic SYS_SECURE_I,
  input wire logic SYS_ENTRY_CALLABLE_I,
  input wire logic SECURE_O,
  input wire logic ENTRY_CALLABLE_O,
  input wire logic [REGION_W-1:0] REGION_O,
  input wire logic REGION_VALID_O,
  input wire logic EXEMPT_O,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O
);
  // Settings can only move at an edge that completes a write.
  logic quiet;
  assign quiet = !(AVS_WRITE_I && !AVS_WAITREQUEST_O);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  region_map_a: assert property (REGION_O == ADDR_I[31:28])
    else $error("region differs from address");
  region_valid_a: assert property (REGION_VALID_O)
    else $error("region valid low");
  entry_mirror_a: assert property (ENTRY_CALLABLE_O == SECURE_O ||
    (SECURE_O == SYS_SECURE_I && ENTRY_CALLABLE_O == SYS_ENTRY_CALLABLE_I))
    else $error("entry flag differs from secure");
  bit_flip_a: assert property ($past(quiet) && $changed(ADDR_I[28]) &&
    $stable(SYS_SECURE_I) |-> $changed(SECURE_O) || SECURE_O == SYS_SECURE_I)
    else $error("secure did not follow bit 28");
  other_bits_a: assert property ($past(quiet) && $stable(ADDR_I[28]) &&
    $stable(SYS_SECURE_I) |-> $stable(SECURE_O))
    else $error("secure moved without bit 28");
  same_cycle_a: assert property ($past(quiet) && $stable(ADDR_I) &&
    $stable({SYS_SECURE_I, SYS_ENTRY_CALLABLE_I})
    |-> $stable({SECURE_O, ENTRY_CALLABLE_O, EXEMPT_O}))
    else $error("answer moved late");
  unique_region_a: assert property ($changed(ADDR_I[31:28])
    |-> $changed(REGION_O)) else $error("region number reused");
  wait_once_a: assert property (!AVS_WAITREQUEST_O |=>
    AVS_WAITREQUEST_O) else $error("waitrequest low too long");
  answer_soon_a: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |-> ##[1:2] !AVS_WAITREQUEST_O)
    else $error("bus request not answered");
  cover property (SECURE_O && EXEMPT_O);
  cover property (SECURE_O != ENTRY_CALLABLE_O);
  cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
endmodule
bind attribution_map attribution_map_asserts chk_u (.*);

// >>> verif/attribution_map_bench.sv
`timescale 1ns/100ps
// Drives the map through the core model and the register bus.
module attribution_map_bench;
  import attribution_pkg::*;
  logic clk, rst, gw, ss, se, rd, wr, vld, sec, ent, ex, wq, flt;
  logic [31:0] tgt, addr, wd, q, rdat;
  logic [3:0] rgn;
  logic [4:0] aa;
  logic [7:0] qry;
  int n_errors, num_checks, cyc;
  // Rows: address, expected secure, expected exempt, default settings.
  logic [33:0] rows [8] = '{{32'h00000000, 2'b10}, {32'h10000000, 2'b00},
    {32'h2FFFFFFC, 2'b10}, {32'hF0000000, 2'b01}, {32'hF0000FFF, 2'b01},
    {32'hF0001000, 2'b00}, {32'hEFFFFFFF, 2'b10}, {32'h7FFFFFFF, 2'b00}};
  core_model cpu_u (.target_i(tgt), .gateway_i(gw), .secure_i(sec),
    .entry_i(ent), .region_i(rgn), .valid_i(vld), .addr_o(addr),
    .fault_o(flt), .query_o(qry));
  attribution_map dut_u (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr),
    .SYS_SECURE_I(ss), .SYS_ENTRY_CALLABLE_I(se), .SECURE_O(sec),
    .ENTRY_CALLABLE_O(ent), .REGION_O(rgn), .REGION_VALID_O(vld),
    .EXEMPT_O(ex), .AVS_ADDRESS_I(aa), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq));
  // Compares one value and counts it.
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus access, held until waitrequest is seen low.
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    rd <= !w;
    wr <= w;
    aa <= a;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // Presents an address and checks the answers in mid-cycle.
  task automatic look(logic [31:0] a, logic s, logic e, logic x);
    tgt <= a;
    @(negedge clk);
    chk("secure", sec, s);
    chk("entry", ent, e);
    chk("region", rgn, a[31:28]);
    chk("valid", vld, 1'b1);
    chk("exempt", ex, x);
    @(posedge clk);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst, gw, ss, se, rd, wr} = 6'h20;
    tgt = 32'h0;
    wd = 32'h0;
    aa = 5'h00;
    repeat (4) @(posedge clk);
    chk("reset wait", wq, 1'b1);
    chk("reset data", rdat, 32'h0);
    rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h3);
    bus(1'b0, OFS_EXEMPT_BASE, 32'h0);
    chk("base reset", q, 32'hF0000000);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("done registers");
    foreach (rows[i]) look(rows[i][33:2], rows[i][1], rows[i][1], rows[i][0]);
    $display("done rows");
    bus(1'b1, OFS_CTRL, 32'h2);
    look(32'h10000000, 1'b1, 1'b1, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h0);
    look(32'hF0000010, 1'b1, 1'b1, 1'b0);
    bus(1'b1, OFS_CTRL, 32'hC);
    ss <= 1'b1;
    look(32'h00000000, 1'b1, 1'b0, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("locked ctrl", q, 32'hC);
    gw <= 1'b1;
    look(32'h00000000, 1'b1, 1'b0, 1'b0);
    chk("fault", flt, 1'b1);
    chk("query", qry, 8'h09);
    ss <= 1'b0;
    se <= 1'b1;
    look(32'h10000000, 1'b0, 1'b1, 1'b0);
    chk("no fault", flt, 1'b0);
    $display("done modes");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    look(32'h00000000, 1'b1, 1'b1, 1'b0);
    $display("done second reset");
    wrap_up();
  end
endmodule
